// ===== logic/uabfc_pkg.sv
// Shared constants, register layout and state encodings of the serial control block.
package uabfc_pkg;

  // Register bus geometry and register offsets.
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFS_BAUD_HIGH = 2'h0;
  localparam logic [1:0] OFS_BAUD_LOW = 2'h1;
  localparam logic [1:0] OFS_FRAME_ONE = 2'h2;
  localparam logic [1:0] OFS_ENABLE_TWO = 2'h3;

  // Reset values; the low divisor byte resets to a non-zero value.
  localparam logic [7:0] BAUD_HIGH_RST = 8'h00;
  localparam logic [7:0] BAUD_LOW_RST = 8'h04;
  localparam logic [7:0] FRAME_ONE_RST = 8'h00;
  localparam logic [7:0] ENABLE_TWO_RST = 8'h00;

  // Writable bit masks; masked bits read as zero.
  localparam logic [7:0] BAUD_HIGH_WMASK = 8'hdf;
  localparam logic [7:0] ENABLE_TWO_WMASK = 8'hfc;

  // Field positions of the baud divisor high register.
  localparam int BDH_BREAK_IE = 7;
  localparam int BDH_EDGE_IE = 6;
  localparam int BDH_DIV_MSB = 4;

  // Field positions of frame control one.
  localparam int C1_LOOP = 7;
  localparam int C1_STOP_WAIT = 6;
  localparam int C1_RX_SOURCE = 5;
  localparam int C1_NINE_BIT = 4;
  localparam int C1_WAKE_ADDR = 3;
  localparam int C1_IDLE_TYPE = 2;
  localparam int C1_PARITY_EN = 1;
  localparam int C1_PARITY_ODD = 0;

  // Field positions of enable control two.
  localparam int C2_TX_EMPTY_IE = 7;
  localparam int C2_TX_DONE_IE = 6;
  localparam int C2_RX_FULL_IE = 5;
  localparam int C2_IDLE_IE = 4;
  localparam int C2_TX_EN = 3;
  localparam int C2_RX_EN = 2;

  // Divisor width, oversampling and frame timing.
  localparam int DIV_W = 13;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] DATA_LAST_8 = 4'd7;
  localparam logic [3:0] DATA_LAST_9 = 4'd8;
  localparam logic [3:0] IDLE_BITS_8 = 4'd10;
  localparam logic [3:0] IDLE_BITS_9 = 4'd11;

  // Frame sequencer states, Gray coded along idle, start, data, stop.
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_START = 2'b01,
    FR_DATA = 2'b11,
    FR_STOP = 2'b10
  } uabfc_frame_t;

endpackage

// ===== logic/uabfc_baud_gen.sv
// Baud generator: one oversample tick every divisor cycles of the bus clock.
`timescale 1ns/1ps
module uabfc_baud_gen #(
  parameter int DIV_W = 13
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [DIV_W-1:0] i_divisor,
  output logic o_tick16
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } uabfc_gen_t;

  uabfc_gen_t st;
  uabfc_gen_t next_st;
  logic wrap;

  // The counter wraps at divisor minus one; a shrunken divisor wraps at once.
  assign wrap = (st.cnt >= i_divisor - DIV_W'(1));
  assign o_tick16 = i_run && wrap;

  // A stopped generator holds its counter at zero so nothing toggles.
  always_comb
  begin
    next_st = st;
    if (!i_run)
    begin
      next_st.cnt = '0;
    end
    else if (wrap)
    begin
      next_st.cnt = '0;
    end
    else
    begin
      next_st.cnt = st.cnt + DIV_W'(1);
    end
  end

  // State register.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule // uabfc_baud_gen

// ===== logic/uabfc_pin_route.sv
// Pin routing for normal, internal loopback and single-wire operation.
`timescale 1ns/1ps
module uabfc_pin_route (
  input wire logic i_loop,
  input wire logic i_single_wire,
  input wire logic i_tx_line,
  input wire logic i_tx_drive,
  input wire logic i_tx_busy,
  input wire logic i_rx_enable,
  input wire logic i_rxd,
  input wire logic i_txd,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_rx_in,
  output logic o_rxd_in_use
);

  // In single-wire mode the pin is driven only while a frame is out, so the
  // receiver can hear the far end in between.
  always_comb
  begin
    o_txd = i_tx_line;
    o_txd_oe = (i_loop && i_single_wire) ? i_tx_busy : i_tx_drive;
    if (!i_loop)
    begin
      o_rx_in = i_rxd;
    end
    else if (i_single_wire)
    begin
      o_rx_in = i_txd;
    end
    else
    begin
      o_rx_in = i_tx_line;
    end
    o_rxd_in_use = i_rx_enable && !i_loop;
  end

endmodule // uabfc_pin_route

// ===== logic/uabfc_ctrl.sv
// Serial control block: registers, baud control, frame engines and pin use.
// Notes on behaviour
// RULE_01 - Upper divisor byte is buffered; working divisor loads on the lower write.
// RULE_02 - A zero divisor stops the baud generator completely.
// RULE_03 - Divisor 1 to 8191 gives bit rate of bus clock over sixteen times it.
// RULE_04 - Generator stays off after reset until a receiver or transmitter enable.
// RULE_05 - Break detect enable lets the break flag raise the interrupt.
// RULE_06 - Receive edge enable lets the edge flag raise the interrupt.
// RULE_07 - Loop bit routes transmitter to receiver and frees the receive pin.
// RULE_08 - Stop in wait freezes serial clocks during wait mode.
// RULE_09 - In loop mode source select picks internal loop or single wire.
// RULE_10 - Frame is start, eight or nine data bits sent LSB first, stop.
// RULE_11 - Wake method selects idle-line or address-mark wakeup.
// RULE_12 - Idle needs 10 or 11 high bits, counted after start or stop.
// RULE_13 - Parity enable makes the top data bit hardware parity.
// RULE_14 - Parity type selects even or odd over the whole character.
// RULE_15 - Transmit empty enable lets that flag raise the interrupt.
// RULE_16 - Transmit complete enable lets that flag raise the interrupt.
// RULE_17 - Receive full enable lets that flag raise the interrupt.
// RULE_18 - Idle enable lets the idle flag raise the interrupt.
// RULE_19 - Control register two is readable and writable at any time.
// RULE_20 - Transmitter enable drives the pin; it is kept until the frame ends. In single-wire loop mode only a frame in progress drives it.
// RULE_21 - Receive pin is released when receiver is off or in loop mode.
// RULE_22 - Interrupt output is high when any enabled flag is set.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module uabfc_ctrl #(
  parameter int DIV_W = 13
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_wait_mode,
  input wire logic [8:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic o_tx_done,
  output logic [8:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_rx_parity_err,
  output logic o_rx_frame_err,
  output logic o_idle_detected,
  output logic o_wakeup,
  input wire logic i_rxd,
  input wire logic i_txd,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_rxd_in_use,
  input wire logic i_tx_empty_flag,
  input wire logic i_tx_complete_flag,
  input wire logic i_rx_full_flag,
  input wire logic i_idle_flag,
  input wire logic i_break_detect_flag,
  input wire logic i_rx_edge_flag,
  output logic o_irq
);

  typedef struct packed {
    logic [7:0] bd_high;
    logic [7:0] bd_low;
    logic [4:0] work_hi;
    logic [7:0] c1;
    logic [7:0] c2;
    logic armed;
    logic [7:0] rdata;
    uabfc_pkg::uabfc_frame_t tx_st;
    logic [8:0] tx_sh;
    logic [3:0] tx_bit;
    logic [3:0] tx_sub;
    logic tx_line;
    logic tx_done;
    uabfc_pkg::uabfc_frame_t rx_st;
    logic [3:0] rx_sub;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic rx_prev;
    logic [8:0] rx_data;
    logic rx_valid;
    logic rx_perr;
    logic rx_ferr;
    logic [3:0] idle_cnt;
    logic [3:0] idle_sub;
    logic idle_done;
    logic idle_pulse;
    logic wake;
  } uabfc_state_t;

  uabfc_state_t st;
  uabfc_state_t next_st;
  logic [DIV_W-1:0] divisor;
  logic gen_run;
  logic tick16;
  logic freeze;
  logic nine;
  logic par_en;
  logic par_odd;
  logic [3:0] data_last;
  logic [3:0] idle_need;
  logic tx_busy;
  logic rx_in;
  logic tx_take;
  logic [8:0] tx_frame;
  logic tx_par;
  logic [8:0] rx_char;
  logic rx_par_ok;

  // Working divisor and generator gating; a frozen generator also stalls both
  // frame engines past a frame start, since after it they only advance on its ticks.
  assign divisor = {st.work_hi, st.bd_low}; // RULE_01
  assign freeze = st.c1[uabfc_pkg::C1_STOP_WAIT] && i_wait_mode; // RULE_08
  assign gen_run = st.armed && (divisor != '0) && !freeze; // RULE_02 RULE_04

  uabfc_baud_gen #(
    .DIV_W(DIV_W)
  ) u_gen (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_run(gen_run),
    .i_divisor(divisor),
    .o_tick16(tick16)
  );

  // Frame format selections.
  assign nine = st.c1[uabfc_pkg::C1_NINE_BIT];
  assign par_en = st.c1[uabfc_pkg::C1_PARITY_EN];
  assign par_odd = st.c1[uabfc_pkg::C1_PARITY_ODD];
  assign data_last = nine ? uabfc_pkg::DATA_LAST_9 : uabfc_pkg::DATA_LAST_8; // RULE_10
  assign idle_need = nine ? uabfc_pkg::IDLE_BITS_9 : uabfc_pkg::IDLE_BITS_8; // RULE_12
  assign tx_busy = (st.tx_st != uabfc_pkg::FR_IDLE);

  // The pin stays ours after the enable drops until the frame is out.
  uabfc_pin_route u_route (
    .i_loop(st.c1[uabfc_pkg::C1_LOOP]),
    .i_single_wire(st.c1[uabfc_pkg::C1_RX_SOURCE]),
    .i_tx_line(st.tx_line),
    .i_tx_drive(st.c2[uabfc_pkg::C2_TX_EN] || tx_busy), // RULE_20
    .i_tx_busy(tx_busy),
    .i_rx_enable(st.c2[uabfc_pkg::C2_RX_EN]),
    .i_rxd(i_rxd),
    .i_txd(i_txd),
    .o_txd(o_txd),
    .o_txd_oe(o_txd_oe),
    .o_rx_in(rx_in),
    .o_rxd_in_use(o_rxd_in_use)
  ); // RULE_07 RULE_09 RULE_21

  // Transmit character with the top data bit replaced by parity when enabled.
  always_comb
  begin
    tx_par = 1'b0;
    tx_frame = i_tx_data;
    if (nine)
    begin
      tx_par = (^i_tx_data[7:0]) ^ par_odd; // RULE_14
      if (par_en)
      begin
        tx_frame = {tx_par, i_tx_data[7:0]}; // RULE_13
      end
    end
    else
    begin
      tx_par = (^i_tx_data[6:0]) ^ par_odd; // RULE_14
      tx_frame = par_en ? {1'b0, tx_par, i_tx_data[6:0]} : {1'b0, i_tx_data[7:0]}; // RULE_13
    end
  end

  // Received character right aligned, and its parity check.
  assign rx_char = nine ? st.rx_sh : {1'b0, st.rx_sh[8:1]};
  assign rx_par_ok = ((nine ? ^rx_char : ^rx_char[7:0]) == par_odd); // RULE_14

  assign o_tx_ready = st.c2[uabfc_pkg::C2_TX_EN] && !tx_busy;
  assign tx_take = i_tx_valid && o_tx_ready;

  // Bus access, transmit engine, receive engine and idle detection.
  always_comb
  begin
    next_st = st;
    next_st.tx_done = 1'b0;
    next_st.rx_valid = 1'b0;
    next_st.idle_pulse = 1'b0;
    next_st.wake = 1'b0;
    next_st.rx_prev = rx_in;
    // Register writes; the high byte only buffers the divisor bits.
    if (i_wr)
    begin
      if (i_addr == uabfc_pkg::OFS_BAUD_HIGH)
      begin
        next_st.bd_high = i_wdata & uabfc_pkg::BAUD_HIGH_WMASK; // RULE_01
      end
      else if (i_addr == uabfc_pkg::OFS_BAUD_LOW)
      begin
        next_st.bd_low = i_wdata;
        next_st.work_hi = st.bd_high[uabfc_pkg::BDH_DIV_MSB:0]; // RULE_01
      end
      else if (i_addr == uabfc_pkg::OFS_FRAME_ONE)
      begin
        next_st.c1 = i_wdata;
      end
      else
      begin
        next_st.c2 = i_wdata & uabfc_pkg::ENABLE_TWO_WMASK; // RULE_19
        if (i_wdata[uabfc_pkg::C2_TX_EN] || i_wdata[uabfc_pkg::C2_RX_EN])
        begin
          next_st.armed = 1'b1; // RULE_04
        end
      end
    end
    // Register reads answer in the next cycle.
    if (i_rd)
    begin
      if (i_addr == uabfc_pkg::OFS_BAUD_HIGH)
      begin
        next_st.rdata = st.bd_high;
      end
      else if (i_addr == uabfc_pkg::OFS_BAUD_LOW)
      begin
        next_st.rdata = st.bd_low;
      end
      else if (i_addr == uabfc_pkg::OFS_FRAME_ONE)
      begin
        next_st.rdata = st.c1;
      end
      else
      begin
        next_st.rdata = st.c2; // RULE_19
      end
    end
    // Transmit: start, data LSB first, stop, sixteen ticks per bit.
    if (tx_take)
    begin
      next_st.tx_st = uabfc_pkg::FR_START;
      next_st.tx_sh = tx_frame;
      next_st.tx_sub = 4'h0;
      next_st.tx_bit = 4'h0;
      next_st.tx_line = 1'b0; // RULE_10
    end
    else if (tick16 && tx_busy)
    begin
      next_st.tx_sub = st.tx_sub + 4'h1; // RULE_03
      if (st.tx_sub == uabfc_pkg::SUB_LAST)
      begin
        case (st.tx_st)
          uabfc_pkg::FR_START:
          begin
            next_st.tx_st = uabfc_pkg::FR_DATA;
            next_st.tx_line = st.tx_sh[0]; // RULE_10
          end
          uabfc_pkg::FR_DATA:
          begin
            if (st.tx_bit == data_last)
            begin
              next_st.tx_st = uabfc_pkg::FR_STOP;
              next_st.tx_line = 1'b1; // RULE_10
            end
            else
            begin
              next_st.tx_bit = st.tx_bit + 4'h1;
              next_st.tx_sh = {1'b0, st.tx_sh[8:1]};
              next_st.tx_line = st.tx_sh[1];
            end
          end
          default:
          begin
            next_st.tx_st = uabfc_pkg::FR_IDLE;
            next_st.tx_done = 1'b1;
          end
        endcase
      end
    end
    // Receive: a falling edge starts a frame, bits are sampled mid cell.
    if (!st.c2[uabfc_pkg::C2_RX_EN])
    begin
      next_st.rx_st = uabfc_pkg::FR_IDLE;
    end
    else if (st.rx_st == uabfc_pkg::FR_IDLE && st.rx_prev && !rx_in)
    begin
      next_st.rx_st = uabfc_pkg::FR_START;
      next_st.rx_sub = 4'h0;
      next_st.rx_bit = 4'h0;
      next_st.idle_cnt = 4'h0;
      next_st.idle_done = 1'b0;
    end
    else if (tick16 && st.rx_st != uabfc_pkg::FR_IDLE)
    begin
      next_st.rx_sub = st.rx_sub + 4'h1;
      case (st.rx_st)
        uabfc_pkg::FR_START:
        begin
          if (st.rx_sub == uabfc_pkg::SUB_MID && rx_in)
          begin
            next_st.rx_st = uabfc_pkg::FR_IDLE;
          end
          else if (st.rx_sub == uabfc_pkg::SUB_LAST)
          begin
            next_st.rx_st = uabfc_pkg::FR_DATA;
          end
        end
        uabfc_pkg::FR_DATA:
        begin
          if (st.rx_sub == uabfc_pkg::SUB_MID)
          begin
            next_st.rx_sh = {rx_in, st.rx_sh[8:1]}; // RULE_10
            // Counting from the start bit lets trailing data ones count.
            if (!st.c1[uabfc_pkg::C1_IDLE_TYPE])
            begin
              next_st.idle_cnt = rx_in ? st.idle_cnt + 4'h1 : 4'h0; // RULE_12
            end
          end
          else if (st.rx_sub == uabfc_pkg::SUB_LAST)
          begin
            if (st.rx_bit == data_last)
            begin
              next_st.rx_st = uabfc_pkg::FR_STOP;
            end
            else
            begin
              next_st.rx_bit = st.rx_bit + 4'h1;
            end
          end
        end
        default:
        begin
          // Return at mid stop so a following start edge is not missed.
          if (st.rx_sub == uabfc_pkg::SUB_MID)
          begin
            next_st.rx_st = uabfc_pkg::FR_IDLE;
            next_st.rx_data = rx_char;
            next_st.rx_valid = 1'b1;
            next_st.rx_perr = par_en && !rx_par_ok; // RULE_13
            next_st.rx_ferr = !rx_in;
            next_st.idle_sub = 4'h0;
            if (st.c1[uabfc_pkg::C1_IDLE_TYPE])
            begin
              next_st.idle_cnt = 4'h0; // RULE_12
            end
            else
            begin
              next_st.idle_cnt = rx_in ? st.idle_cnt + 4'h1 : 4'h0; // RULE_12
            end
            // Address-mark wakeup fires on a character with its top bit set.
            if (st.c1[uabfc_pkg::C1_WAKE_ADDR] && (nine ? rx_char[8] : rx_char[7]))
            begin
              next_st.wake = 1'b1; // RULE_11
            end
          end
        end
      endcase
    end
    else if (tick16 && st.rx_st == uabfc_pkg::FR_IDLE)
    begin
      // Line idle: count whole high bit times, saturating.
      next_st.idle_sub = st.idle_sub + 4'h1;
      if (st.idle_sub == uabfc_pkg::SUB_LAST)
      begin
        if (!rx_in)
        begin
          next_st.idle_cnt = 4'h0;
        end
        else if (st.idle_cnt != 4'hf)
        begin
          next_st.idle_cnt = st.idle_cnt + 4'h1; // RULE_12
        end
      end
    end
    // One idle report per quiet period; the next start bit re-arms it.
    if (st.c2[uabfc_pkg::C2_RX_EN] && !st.idle_done && st.idle_cnt >= idle_need)
    begin
      next_st.idle_done = 1'b1;
      next_st.idle_pulse = 1'b1; // RULE_12
      next_st.wake = !st.c1[uabfc_pkg::C1_WAKE_ADDR]; // RULE_11
    end
  end

  // State register with documented reset values.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      st <= '0;
      st.bd_high <= uabfc_pkg::BAUD_HIGH_RST;
      st.bd_low <= uabfc_pkg::BAUD_LOW_RST;
      st.c1 <= uabfc_pkg::FRAME_ONE_RST;
      st.c2 <= uabfc_pkg::ENABLE_TWO_RST;
      st.tx_st <= uabfc_pkg::FR_IDLE;
      st.rx_st <= uabfc_pkg::FR_IDLE;
      st.tx_line <= 1'b1;
      st.rx_prev <= 1'b1;
      st.idle_done <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs. The interrupt is purely a gate of flags by enables.
  assign o_rdata = st.rdata;
  assign o_tx_done = st.tx_done;
  assign o_rx_data = st.rx_data;
  assign o_rx_valid = st.rx_valid;
  assign o_rx_parity_err = st.rx_perr;
  assign o_rx_frame_err = st.rx_ferr;
  assign o_idle_detected = st.idle_pulse;
  assign o_wakeup = st.wake;
  assign o_irq = (i_break_detect_flag && st.bd_high[uabfc_pkg::BDH_BREAK_IE]) // RULE_05
    || (i_rx_edge_flag && st.bd_high[uabfc_pkg::BDH_EDGE_IE]) // RULE_06
    || (i_tx_empty_flag && st.c2[uabfc_pkg::C2_TX_EMPTY_IE]) // RULE_15
    || (i_tx_complete_flag && st.c2[uabfc_pkg::C2_TX_DONE_IE]) // RULE_16
    || (i_rx_full_flag && st.c2[uabfc_pkg::C2_RX_FULL_IE]) // RULE_17
    || (i_idle_flag && st.c2[uabfc_pkg::C2_IDLE_IE]); // RULE_18 RULE_22

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  // Checks on divisor loading, generator timing, interrupts, loop routing, parity, control two writes and the start bit.
  sequence s_tick_div2;
    tick16 && gen_run && divisor == 13'd2 ##1 !tick16 && gen_run && divisor == 13'd2;
  endsequence
  chk_divisor_hold: assert property (i_wr && i_addr == uabfc_pkg::OFS_BAUD_HIGH |=> $stable(divisor)) else $error("divisor moved on high write"); // RULE_01
  chk_divisor_load: assert property (i_wr && i_addr == uabfc_pkg::OFS_BAUD_LOW |=> divisor[7:0] == $past(i_wdata) && divisor[12:8] == $past(st.bd_high[4:0])) else $error("divisor not loaded"); // RULE_01
  chk_zero_stops: assert property (divisor == '0 |-> !tick16) else $error("tick with zero divisor"); // RULE_02
  chk_tick_spacing: assert property (s_tick_div2 |=> tick16) else $error("tick spacing wrong"); // RULE_03
  chk_armed_first: assert property (!st.armed |-> !tick16) else $error("tick before enable"); // RULE_04
  chk_freeze_wait: assert property (freeze |-> !tick16 ##1 (!freeze || !tick16)) else $error("tick in wait freeze"); // RULE_08
  chk_break_irq: assert property (i_break_detect_flag && st.bd_high[7] |-> o_irq) else $error("break irq missing"); // RULE_05
  chk_edge_irq: assert property (i_rx_edge_flag && st.bd_high[6] |-> o_irq) else $error("edge irq missing"); // RULE_06
  chk_loop_route: assert property (st.c1[7] && !st.c1[5] |-> rx_in == st.tx_line && !o_rxd_in_use) else $error("loop route wrong"); // RULE_07 RULE_09 RULE_21
  chk_parity_gen: assert property (tx_take && par_en |=> (nine ? ^st.tx_sh : ^st.tx_sh[7:0]) == par_odd) else $error("parity wrong"); // RULE_13 RULE_14
  chk_ctrl2_write: assert property (i_wr && i_addr == uabfc_pkg::OFS_ENABLE_TWO |=> st.c2 == ($past(i_wdata) & 8'hfc)) else $error("control two lost write"); // RULE_19
  chk_tx_hold_pin: assert property (tx_take |=> !o_txd ##0 o_txd_oe) else $error("start bit not driven"); // RULE_10 RULE_20

endmodule // uabfc_ctrl

// ===== verif/uabfc_remote.sv
// Remote serial node model standing on the far side of the serial pins.
`timescale 1ns/1ps
module uabfc_remote #(
  parameter int BIT_CYC = 32
) (
  input wire logic i_mclk,
  input wire logic i_line,
  input wire logic i_nine,
  output logic o_rxd,
  output logic [8:0] o_got
);
  // Sends one frame LSB first; the line idles high between frames.
  task automatic send(input logic [8:0] ch);
    @(posedge i_mclk);
    o_rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge i_mclk);
    for (int i = 0; i < (i_nine ? 9 : 8); i++)
    begin
      o_rxd <= ch[i];
      repeat (BIT_CYC) @(posedge i_mclk);
    end
    o_rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge i_mclk);
  endtask

  // Samples mid bit; a frame at another rate is garbled, then it resyncs.
  initial
  begin
    logic [8:0] g;
    o_rxd = 1'b1;
    o_got = 9'h000;
    forever
    begin
      @(negedge i_line);
      g = 9'h000;
      repeat (BIT_CYC / 2) @(posedge i_mclk);
      for (int i = 0; i < (i_nine ? 9 : 8); i++)
      begin
        repeat (BIT_CYC) @(posedge i_mclk);
        g[i] = i_line;
      end
      repeat (BIT_CYC) @(posedge i_mclk);
      o_got = g;
    end
  end
endmodule // uabfc_remote

// ===== verif/tb_top.sv
// Self-checking bench for the serial control block.
`timescale 1ns/1ps
module tb_top;
  localparam int BIT_CYC = 32;
  logic i_mclk, i_reset, i_wr, i_rd, i_wait_mode, i_tx_valid, i_rxd, line, err, idl, wk;
  logic o_tx_ready, o_tx_done, o_rx_valid, o_rx_parity_err, o_rx_frame_err;
  logic o_txd, o_txd_oe, o_rxd_in_use, o_irq;
  logic [1:0] i_addr;
  logic [7:0] i_wdata, o_rdata, rv, a, b, c1;
  logic [8:0] i_tx_data, o_rx_data, far_got, r;
  logic [5:0] flags;
  logic [7:0] rst [4] = '{8'h00, 8'h04, 8'h00, 8'h00};
  logic [7:0] modes [6] = '{8'h00, 8'h10, 8'h02, 8'h03, 8'h12, 8'h13};
  int failures, tests_run, cycles, idles, wakes;

  // The transmit pin has a pull-up, so a released pin reads high.
  assign line = o_txd_oe ? o_txd : 1'b1;

  uabfc_ctrl #(.DIV_W(uabfc_pkg::DIV_W)) uut (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_wait_mode(i_wait_mode), .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid),
    .o_tx_ready(o_tx_ready), .o_tx_done(o_tx_done), .o_rx_data(o_rx_data),
    .o_rx_valid(o_rx_valid), .o_rx_parity_err(o_rx_parity_err),
    .o_rx_frame_err(o_rx_frame_err), .o_idle_detected(idl), .o_wakeup(wk), .i_rxd(i_rxd),
    .i_txd(line), .o_txd(o_txd), .o_txd_oe(o_txd_oe), .o_rxd_in_use(o_rxd_in_use),
    .i_tx_empty_flag(flags[0]), .i_tx_complete_flag(flags[1]), .i_rx_full_flag(flags[2]),
    .i_idle_flag(flags[3]), .i_break_detect_flag(flags[4]), .i_rx_edge_flag(flags[5]),
    .o_irq(o_irq));

  uabfc_remote #(.BIT_CYC(BIT_CYC)) remote (.i_mclk(i_mclk), .i_line(line),
    .i_nine(c1[uabfc_pkg::C1_NINE_BIT]), .o_rxd(i_rxd), .o_got(far_got));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] ad, output logic [7:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
  endtask

  // Waits, bounded, for transmit ready, then offers a character for one cycle.
  task automatic send(input logic [8:0] ch);
    @(posedge i_mclk);
    for (int k = 0; k < 20000 && o_tx_ready !== 1'b1; k++)
      @(posedge i_mclk);
    i_tx_data <= ch;
    i_tx_valid <= 1'b1;
    @(posedge i_mclk);
    i_tx_valid <= 1'b0;
  endtask

  // Waits, bounded, for transmit done (sel 0) or receive valid (sel 1).
  task automatic wait_pulse(input int sel);
    int k;
    k = 0;
    @(negedge i_mclk);
    while (k < 20000 && ((sel == 0) ? o_tx_done : o_rx_valid) !== 1'b1)
    begin
      k++;
      @(negedge i_mclk);
    end
    check("pulse seen", k < 20000, 1'b1);
  endtask

  // Counts the start bit length, allowing one divisor of tick phase.
  task automatic measure(input int exp, input int div);
    int c;
    c = 0;
    send(9'h0ff);
    @(negedge i_mclk);
    while (o_txd === 1'b0 && c < 9000)
    begin
      c++;
      @(negedge i_mclk);
    end
    check("bit time", c + div >= exp && c <= exp + div, 1'b1);
  endtask

  // Character expected on the wire: parity, when on, replaces the top data bit.
  function automatic logic [8:0] frame(input logic [8:0] d, input logic [7:0] c);
    logic [8:0] f;
    int m;
    m = c[uabfc_pkg::C1_NINE_BIT] ? 8 : 7;
    f = c[uabfc_pkg::C1_NINE_BIT] ? d : {1'b0, d[7:0]};
    if (c[uabfc_pkg::C1_PARITY_EN])
    begin
      f[m] = 1'b0;
      f[m] = (^f) ^ c[uabfc_pkg::C1_PARITY_ODD];
    end
    return f;
  endfunction

  // Bench clock.
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // Cuts a hung run short.
  always @(posedge i_mclk)
  begin
    cycles++;
    idles += idl;
    wakes += wk;
    if (cycles == 90000)
    begin
      failures++;
      summarize();
    end
  end

  // Main sequence.
  initial
  begin
    {i_reset, i_wr, i_rd, i_wait_mode, i_tx_valid} = 5'h10;
    {i_addr, i_wdata, i_tx_data, flags, c1} = '0;
    void'($urandom(40476));
    repeat (16) @(posedge i_mclk);
    i_reset <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd(i, rv);
      check("reset value", rv, rst[i]);
    end
    check("idle txd", o_txd, 1'b1);
    // Random enables and flags, with read-back of both enable registers.
    for (int t = 0; t < 24; t++)
    begin
      a = $urandom;
      b = $urandom;
      wr(uabfc_pkg::OFS_BAUD_HIGH, a);
      wr(uabfc_pkg::OFS_ENABLE_TWO, b);
      flags <= $urandom;
      rd(uabfc_pkg::OFS_ENABLE_TWO, rv);
      check("reg two", rv, b & uabfc_pkg::ENABLE_TWO_WMASK);
      rd(uabfc_pkg::OFS_BAUD_HIGH, rv);
      check("high reg", rv, a & uabfc_pkg::BAUD_HIGH_WMASK);
      check("irq", o_irq, |(flags & {a[6], a[7], b[4], b[5], b[6], b[7]}));
    end
    $display("test registers and interrupt done");
    wr(uabfc_pkg::OFS_BAUD_HIGH, 8'h00);
    wr(uabfc_pkg::OFS_BAUD_LOW, 8'h02);
    wr(uabfc_pkg::OFS_ENABLE_TWO, 8'h0c);
    // Every frame format and parity setting, in both directions.
    for (int t = 0; t < 6; t++)
    begin
      c1 = modes[t];
      wr(uabfc_pkg::OFS_FRAME_ONE, c1);
      r = $urandom;
      send(r);
      wait_pulse(0);
      check("tx frame", far_got, frame(r, c1));
      r = $urandom & (c1[uabfc_pkg::C1_NINE_BIT] ? 9'h1ff : 9'h0ff);
      err = c1[uabfc_pkg::C1_PARITY_EN] & ((^r) != c1[uabfc_pkg::C1_PARITY_ODD]);
      fork
        remote.send(r);
        wait_pulse(1);
      join
      check("rx data", o_rx_data, r);
      check("rx parity", o_rx_parity_err, err);
      check("rx framing", o_rx_frame_err, 1'b0);
    end
    $display("test frame formats done");
    c1 = 8'h00;
    for (int s = 0; s < 2; s++)
    begin
      wr(uabfc_pkg::OFS_FRAME_ONE, 8'h80 | (s << uabfc_pkg::C1_RX_SOURCE));
      r = $urandom;
      fork
        send(r);
        wait_pulse(1);
      join
      check("loop data", o_rx_data, frame(r, c1));
      check("rx pin use", o_rxd_in_use, 1'b0);
      wait_pulse(0);
    end
    wr(uabfc_pkg::OFS_FRAME_ONE, 8'h00);
    @(negedge i_mclk);
    check("rx pin use", o_rxd_in_use, 1'b1);
    $display("test loop modes done");
    // Zero divisor, then stop-in-wait, must both hold the start bit.
    for (int m = 0; m < 2; m++)
    begin
      if (m == 0)
        wr(uabfc_pkg::OFS_BAUD_LOW, 8'h00);
      else
        wr(uabfc_pkg::OFS_FRAME_ONE, 8'h40);
      i_wait_mode <= (m == 1);
      send(9'h0ff);
      repeat (300) @(posedge i_mclk);
      @(negedge i_mclk);
      check("stalled txd", o_txd, 1'b0);
      wr(uabfc_pkg::OFS_BAUD_LOW, 8'h02);
      i_wait_mode <= 1'b0;
      wr(uabfc_pkg::OFS_FRAME_ONE, 8'h00);
      wait_pulse(0);
    end
    $display("test stalls done");
    wr(uabfc_pkg::OFS_BAUD_HIGH, 8'h01);
    measure(16 * 2, 2);
    wait_pulse(0);
    wr(uabfc_pkg::OFS_BAUD_LOW, 8'h00);
    measure(16 * 256, 256);
    check("idle seen", idles != 0, 1'b1);
    check("idle wakeups", wakes, idles);
    $display("test divisor done");
    summarize();
  end
endmodule // tb_top
